// ---- inc/bsx_pkg.sv ----
// Package for the bit, shift and flag execution unit.
`default_nettype none
package bsx_pkg;

    // Operation codes presented on the issue port.
    typedef enum logic [4:0] {
        BSX_OP_IDLE       = 5'h00,
        BSX_OP_PUSH       = 5'h01,
        BSX_OP_POP        = 5'h02,
        BSX_OP_IO_SET     = 5'h03,
        BSX_OP_IO_CLR     = 5'h04,
        BSX_OP_LSL        = 5'h05,
        BSX_OP_LSR        = 5'h06,
        BSX_OP_ROL        = 5'h07,
        BSX_OP_ROR        = 5'h08,
        BSX_OP_ASR        = 5'h09,
        BSX_OP_SWAP       = 5'h0a,
        BSX_OP_FLAG_SET   = 5'h0b,
        BSX_OP_FLAG_CLR   = 5'h0c,
        BSX_OP_BIT_TO_T   = 5'h0d,
        BSX_OP_T_TO_BIT   = 5'h0e,
        BSX_OP_SLEEP      = 5'h0f,
        BSX_OP_WDOG       = 5'h10,
        BSX_OP_BREAK      = 5'h11
    } bsx_op_type;

    // Status register bit positions.
    localparam int unsigned BSX_FLAG_C = 0;
    localparam int unsigned BSX_FLAG_Z = 1;
    localparam int unsigned BSX_FLAG_N = 2;
    localparam int unsigned BSX_FLAG_V = 3;
    localparam int unsigned BSX_FLAG_S = 4;
    localparam int unsigned BSX_FLAG_H = 5;
    localparam int unsigned BSX_FLAG_T = 6;
    localparam int unsigned BSX_FLAG_I = 7;

    localparam logic [7:0] BSX_STATUS_FLAGS_REGISTER_RST = 8'h00;
    localparam logic [7:0] BSX_DATA_RST = 8'h00;
    localparam logic [5:0] BSX_ADDR_RST = 6'h00;

    // Cycle counts of the two-cycle operations and the single ones.
    localparam logic [1:0] BSX_CYC_ONE = 2'h1;
    localparam logic [1:0] BSX_CYC_TWO = 2'h2;

    // Execution phases, Gray coded along idle, second, halt.
    typedef enum logic [1:0] {
        BSX_ST_IDLE   = 2'b00,
        BSX_ST_SECOND = 2'b01,
        BSX_ST_HALT   = 2'b11
    } bsx_state_type;

endpackage : bsx_pkg
`default_nettype wire

// ---- core/bsx_stack_mem.sv ----
// Stack memory of the execution unit with a registered read port.
`timescale 1ns/100ps
`default_nettype none
module bsx_stack_mem #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 64
) (
    input  wire logic                     i_sys_clk,  // Core clock.
    input  wire logic                     i_wr_en,    // Write strobe.
    input  wire logic [$clog2(DEPTH)-1:0] i_addr,     // Word address.
    input  wire logic [WIDTH-1:0]         i_wr_data,  // Write data.
    output logic      [WIDTH-1:0]         o_rd_data   // Registered read.
);
    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("bsx_stack_mem: unsupported geometry");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];

    // Memory arrays carry no reset so that they map onto block storage.
    always_ff @(posedge i_sys_clk) begin
        if (i_wr_en) begin
            mem[i_addr] <= i_wr_data;
        end
        o_rd_data <= mem[i_addr];
    end
endmodule // bsx_stack_mem
`default_nettype wire

// ---- core/bsx_exec_unit.sv ----
// Execution unit for the bit, shift, stack and status flag operations.
//
// Summary of operation
// - Push takes two cycles, flags unchanged.
// - Pop takes two cycles, flags unchanged.
// - I/O bit set, two cycles, no flags.
// - I/O bit clear, two cycles, no flags.
// - Shift left, zero in, updates ZCNV.
// - Shift right, zero in, updates ZCNV.
// - Rotate left through carry, updates ZCNV.
// - Rotate right through carry, updates ZCNV.
// - Arithmetic right shift keeps sign, ZCNV.
// - Copy register bit into transfer flag.
// - Copy transfer flag into register bit.
// - Set or clear negative flag alone.
// - Set or clear overflow flag alone.
// - Set or clear half carry flag.
// - Set or clear global interrupt flag.
// - Set or clear signed test flag.
// - Sleep issues one cycle, pulses sleep request.
// - Watchdog restart pulses restart, one cycle.
// - Break only acts with debug enabled.
`timescale 1ns/100ps
`default_nettype none
module bsx_exec_unit
    import bsx_pkg::*;
#(
    parameter int unsigned STACK_DEPTH = 64
) (
    input  wire logic        i_sys_clk,    // Core clock, 40 MHz.
    input  wire logic        i_arst_n,     // Asynchronous reset, low.
    input  wire logic        i_issue,      // Operation issue strobe.
    input  wire bsx_op_type  i_op,         // Operation code.
    input  wire logic [7:0]  i_operand,    // Register or I/O byte.
    input  wire logic [2:0]  i_bit_sel,    // Bit or flag selector.
    input  wire logic        i_debug_en,   // On-chip debug active.
    output logic             o_busy,       // Two-cycle op or break halt in progress.
    output logic             o_done,       // Result valid pulse.
    output logic [7:0]       o_result,     // Result byte.
    output logic             o_result_wr,  // Result writes back.
    output logic [7:0]       o_status_flags_register,       // Status flags register.
    output logic [5:0]       o_stack_ptr,  // Stack pointer.
    output logic             o_sleep_req,  // Sleep request pulse.
    output logic             o_wdog_rst,   // Watchdog restart pulse.
    output logic             o_break_req   // Debug break pulse.
);
    localparam int unsigned AW = $clog2(STACK_DEPTH);

    initial begin
        if (AW != 6) begin
            $error("bsx_exec_unit: STACK_DEPTH must be 64");
        end
    end

    typedef struct packed {
        bsx_state_type st;
        bsx_op_type    op;
        logic [7:0]    hold;
        logic          busy;
        logic          done;
        logic [7:0]    result;
        logic          result_wr;
        logic [7:0]    status_flags_register;
        logic [5:0]    sp;
        logic          sleep_req;
        logic          wdog_rst;
        logic          break_req;
    } bsx_regs_type;

    bsx_regs_type r_q;
    bsx_regs_type r_d;

    logic       mem_wr;
    logic [5:0] mem_addr;
    logic [7:0] mem_rd;

    // Flags of a shift: Z, N from result, C = bit shifted out, V = N xor C, S = N xor V.
    function automatic logic [7:0] shift_flags(input logic [7:0] status_flags_register,
                                               input logic [7:0] res,
                                               input logic       cout);
        logic [7:0] f;
        f = status_flags_register;
        f[BSX_FLAG_Z] = (res == 8'h00);
        f[BSX_FLAG_C] = cout;
        f[BSX_FLAG_N] = res[7];
        f[BSX_FLAG_V] = res[7] ^ cout;
        f[BSX_FLAG_S] = cout;
        return f;
    endfunction

    // Pop reads one below the pointer; push writes at the pointer.
    always_comb begin
        mem_wr   = 1'b0;
        mem_addr = r_q.sp;
        if (i_issue && !r_q.busy && i_op == BSX_OP_PUSH) begin
            mem_wr = 1'b1;
        end else if (i_issue && !r_q.busy && i_op == BSX_OP_POP) begin
            mem_addr = r_q.sp - 6'h01;
        end
    end

    bsx_stack_mem #(
        .WIDTH (8),
        .DEPTH (STACK_DEPTH)
    ) u_stack (
        .i_sys_clk (i_sys_clk),
        .i_wr_en   (mem_wr),
        .i_addr    (mem_addr),
        .i_wr_data (i_operand),
        .o_rd_data (mem_rd)
    );

    always_comb begin
        logic [7:0] res;
        res = 8'h00;
        r_d = r_q;
        r_d.done      = 1'b0;
        r_d.result_wr = 1'b0;
        r_d.sleep_req = 1'b0;
        r_d.wdog_rst  = 1'b0;
        r_d.break_req = 1'b0;
        unique case (r_q.st)
            BSX_ST_IDLE: begin
                if (i_issue) begin
                    r_d.op   = i_op;
                    r_d.hold = i_operand;
                    unique case (i_op)
                        BSX_OP_PUSH: begin
                            r_d.sp   = r_q.sp + 6'h01;
                            r_d.busy = 1'b1;
                            r_d.st   = BSX_ST_SECOND;
                        end
                        BSX_OP_POP: begin
                            r_d.sp   = r_q.sp - 6'h01;
                            r_d.busy = 1'b1;
                            r_d.st   = BSX_ST_SECOND;
                        end
                        BSX_OP_IO_SET, BSX_OP_IO_CLR: begin
                            // Read-modify-write of the I/O byte spans two
                            // cycles; flags are left alone.
                            r_d.busy = 1'b1;
                            r_d.st   = BSX_ST_SECOND;
                        end
                        BSX_OP_LSL: begin
                            res = {i_operand[6:0], 1'b0};
                            r_d.status_flags_register = shift_flags(r_q.status_flags_register, res,
                                                   i_operand[7]);
                            r_d.result_wr = 1'b1;
                        end
                        BSX_OP_LSR: begin
                            res = {1'b0, i_operand[7:1]};
                            r_d.status_flags_register = shift_flags(r_q.status_flags_register, res,
                                                   i_operand[0]);
                            r_d.result_wr = 1'b1;
                        end
                        BSX_OP_ROL: begin
                            res = {i_operand[6:0],
                                   r_q.status_flags_register[BSX_FLAG_C]};
                            r_d.status_flags_register = shift_flags(r_q.status_flags_register, res,
                                                   i_operand[7]);
                            r_d.result_wr = 1'b1;
                        end
                        BSX_OP_ROR: begin
                            res = {r_q.status_flags_register[BSX_FLAG_C],
                                   i_operand[7:1]};
                            r_d.status_flags_register = shift_flags(r_q.status_flags_register, res,
                                                   i_operand[0]);
                            r_d.result_wr = 1'b1;
                        end
                        BSX_OP_ASR: begin
                            res = {i_operand[7], i_operand[7:1]};
                            r_d.status_flags_register = shift_flags(r_q.status_flags_register, res,
                                                   i_operand[0]);
                            r_d.result_wr = 1'b1;
                        end
                        BSX_OP_SWAP: begin
                            res = {i_operand[3:0], i_operand[7:4]};
                            r_d.result_wr = 1'b1;
                        end
                        BSX_OP_FLAG_SET: begin
                            // Selector reaches N, V, H, I, S, C, Z, T.
                            r_d.status_flags_register[i_bit_sel] = 1'b1;
                        end
                        BSX_OP_FLAG_CLR: begin
                            r_d.status_flags_register[i_bit_sel] = 1'b0;
                        end
                        BSX_OP_BIT_TO_T: begin
                            r_d.status_flags_register[BSX_FLAG_T] =
                                i_operand[i_bit_sel];
                        end
                        BSX_OP_T_TO_BIT: begin
                            res = i_operand;
                            res[i_bit_sel] = r_q.status_flags_register[BSX_FLAG_T];
                            r_d.result_wr = 1'b1;
                        end
                        BSX_OP_SLEEP: begin
                            r_d.sleep_req = 1'b1;
                        end
                        BSX_OP_WDOG: begin
                            r_d.wdog_rst = 1'b1;
                        end
                        BSX_OP_BREAK: begin
                            // Without debug the break is a plain idle cycle.
                            if (i_debug_en) begin
                                r_d.break_req = 1'b1;
                                r_d.busy      = 1'b1;
                                r_d.st        = BSX_ST_HALT;
                            end
                        end
                        default: begin
                            res = 8'h00;
                        end
                    endcase
                    r_d.result = res;
                    if (r_d.st == BSX_ST_IDLE) begin
                        r_d.done = 1'b1;
                    end
                end
            end
            BSX_ST_SECOND: begin
                unique case (r_q.op)
                    BSX_OP_POP: begin
                        r_d.result    = mem_rd;
                        r_d.result_wr = 1'b1;
                    end
                    BSX_OP_IO_SET: begin
                        r_d.result = r_q.hold;
                        r_d.result[i_bit_sel] = 1'b1;
                        r_d.result_wr = 1'b1;
                    end
                    BSX_OP_IO_CLR: begin
                        r_d.result = r_q.hold;
                        r_d.result[i_bit_sel] = 1'b0;
                        r_d.result_wr = 1'b1;
                    end
                    default: begin
                        r_d.result = r_q.hold;
                    end
                endcase
                r_d.done = 1'b1;
                r_d.busy = 1'b0;
                r_d.st   = BSX_ST_IDLE;
            end
            BSX_ST_HALT: begin
                // Break holds the unit until the debugger drops its enable,
                // so its length is set by the debugger, not by this unit.
                if (!i_debug_en) begin
                    r_d.busy = 1'b0;
                    r_d.done = 1'b1;
                    r_d.st   = BSX_ST_IDLE;
                end
            end
            default: begin
                r_d.st   = BSX_ST_IDLE;
                r_d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r_q <= '{st: BSX_ST_IDLE, op: BSX_OP_IDLE, hold: BSX_DATA_RST,
                     busy: 1'b0, done: 1'b0, result: BSX_DATA_RST,
                     result_wr: 1'b0, status_flags_register: BSX_STATUS_FLAGS_REGISTER_RST, sp: BSX_ADDR_RST,
                     sleep_req: 1'b0, wdog_rst: 1'b0, break_req: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    assign o_busy      = r_q.busy;
    assign o_done      = r_q.done;
    assign o_result    = r_q.result;
    assign o_result_wr = r_q.result_wr;
    assign o_status_flags_register      = r_q.status_flags_register;
    assign o_stack_ptr = r_q.sp;
    assign o_sleep_req = r_q.sleep_req;
    assign o_wdog_rst  = r_q.wdog_rst;
    assign o_break_req = r_q.break_req;
endmodule // bsx_exec_unit
`default_nettype wire

// ---- verification/bsx_exec_monitor.sv ----
// Assertion checker for the bit, shift and flag execution unit.
`timescale 1ns/100ps
`default_nettype none
module bsx_exec_monitor
    import bsx_pkg::*;
(
    input wire logic       i_sys_clk,   // Core clock.
    input wire logic       i_arst_n,    // Reset, low.
    input wire logic       i_issue,     // Issue strobe.
    input wire bsx_op_type i_op,        // Operation code.
    input wire logic [7:0] i_operand,   // Operand byte.
    input wire logic [2:0] i_bit_sel,   // Bit selector.
    input wire logic       o_busy,      // Busy.
    input wire logic       o_done,      // Done pulse.
    input wire logic [7:0] o_result,    // Result byte.
    input wire logic [7:0] o_status_flags_register,      // Status flags.
    input wire logic       o_wdog_rst   // Watchdog pulse.
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);

    sequence s_take(bsx_op_type op);
        i_issue && !o_busy && i_op == op;
    endsequence
    sequence s_two_step;
        o_busy && !o_done ##1 o_done && !o_busy;
    endsequence

    a_push_two_step: assert property (s_take(BSX_OP_PUSH) |=>
        s_two_step)
        else $error("push did not finish in two cycles");
    a_pop_two_step: assert property (s_take(BSX_OP_POP) |=>
        s_two_step)
        else $error("pop did not finish in two cycles");
    a_stack_flags_kept: assert property ((s_take(BSX_OP_PUSH) or
        s_take(BSX_OP_POP)) |=> $stable(o_status_flags_register)[*2])
        else $error("stack operation changed the flags");
    a_io_set_bit: assert property (s_take(BSX_OP_IO_SET) |=> s_two_step
        ##0 o_result == ($past(i_operand, 2) | (8'h01 << $past(i_bit_sel, 2))))
        else $error("io bit set result wrong");
    a_io_clear_bit: assert property (s_take(BSX_OP_IO_CLR) |=> s_two_step
        ##0 o_result == ($past(i_operand, 2) & ~(8'h01 << $past(i_bit_sel, 2))))
        else $error("io bit clear result wrong");
    a_shift_left: assert property (s_take(BSX_OP_LSL) |=> o_done &&
        o_result == {$past(i_operand[6:0]), 1'b0} &&
        o_status_flags_register[BSX_FLAG_C] == $past(i_operand[7]))
        else $error("left shift wrong");
    a_shift_right: assert property (s_take(BSX_OP_LSR) |=> o_done &&
        o_result == {1'b0, $past(i_operand[7:1])} &&
        o_status_flags_register[BSX_FLAG_C] == $past(i_operand[0]))
        else $error("right shift wrong");
    a_rotate_left: assert property (s_take(BSX_OP_ROL) |=> o_done &&
        o_result == {$past(i_operand[6:0]), $past(o_status_flags_register[BSX_FLAG_C])} &&
        o_status_flags_register[BSX_FLAG_C] == $past(i_operand[7]))
        else $error("left rotate wrong");
    a_rotate_right: assert property (s_take(BSX_OP_ROR) |=> o_done &&
        o_result == {$past(o_status_flags_register[BSX_FLAG_C]), $past(i_operand[7:1])} &&
        o_status_flags_register[BSX_FLAG_C] == $past(i_operand[0]))
        else $error("right rotate wrong");
    a_arith_right: assert property (s_take(BSX_OP_ASR) |=> o_done &&
        o_result == {$past(i_operand[7]), $past(i_operand[7:1])})
        else $error("arithmetic shift wrong");
    a_swap_nibbles: assert property (s_take(BSX_OP_SWAP) |=> o_done &&
        o_result == {$past(i_operand[3:0]), $past(i_operand[7:4])} &&
        $stable(o_status_flags_register))
        else $error("nibble swap wrong");
    a_flag_set_sel: assert property (s_take(BSX_OP_FLAG_SET) |=>
        o_status_flags_register == ($past(o_status_flags_register) | (8'h01 << $past(i_bit_sel))))
        else $error("flag set touched wrong bits");
    // A second restart issued back to back legally keeps the pulse high.
    a_wdog_pulse: assert property (s_take(BSX_OP_WDOG) |=>
        o_wdog_rst && o_done ##1
        (!o_wdog_rst || $past(i_issue && !o_busy && i_op == BSX_OP_WDOG)))
        else $error("watchdog pulse wrong");
endmodule // bsx_exec_monitor
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking testbench for the bit, shift and flag execution unit.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import bsx_pkg::*;
    logic       i_sys_clk, i_arst_n, i_issue, i_debug_en;
    bsx_op_type i_op;
    logic [7:0] i_operand, o_result, o_status_flags_register, status_flags_register;
    logic [7:0] stk [64];
    logic [7:0] vals [4] = '{8'h81, 8'h00, 8'h40, 8'hfe};
    logic [2:0] i_bit_sel;
    logic [5:0] o_stack_ptr, sp;
    logic       o_busy, o_done, o_result_wr, o_sleep_req, o_wdog_rst;
    logic       o_break_req;
    int         mismatches, checked, cyc;

    bsx_exec_unit uut (.i_sys_clk, .i_arst_n, .i_issue, .i_op, .i_operand,
        .i_bit_sel, .i_debug_en, .o_busy, .o_done, .o_result, .o_result_wr,
        .o_status_flags_register, .o_stack_ptr, .o_sleep_req, .o_wdog_rst, .o_break_req);

    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("ERROR %0t: %s", $time, msg);
        end
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Inputs always move 1 ns after the edge so no race with sampling.
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic wait_done();
        cyc = 1;
        while (o_done !== 1'b1 && cyc < 4) begin
            tick(1);
            cyc++;
        end
        if (o_done !== 1'b1) begin
            chk(1'b0, "done never came");
            test_done();
        end
    endtask

    task automatic do_op(input bsx_op_type op, input logic [7:0] a,
                         input logic [2:0] sel);
        logic [7:0] r;
        logic       c, wr, two;
        r = a;
        c = status_flags_register[BSX_FLAG_C];
        two = op inside {BSX_OP_PUSH, BSX_OP_POP, BSX_OP_IO_SET,
            BSX_OP_IO_CLR};
        wr = op inside {BSX_OP_LSL, BSX_OP_LSR, BSX_OP_ROL, BSX_OP_ROR,
            BSX_OP_ASR, BSX_OP_SWAP, BSX_OP_IO_SET, BSX_OP_IO_CLR,
            BSX_OP_T_TO_BIT, BSX_OP_POP};
        case (op)
            BSX_OP_LSL: r = {a[6:0], 1'b0};
            BSX_OP_LSR: r = {1'b0, a[7:1]};
            BSX_OP_ROL: r = {a[6:0], c};
            BSX_OP_ROR: r = {c, a[7:1]};
            BSX_OP_ASR: r = {a[7], a[7:1]};
            BSX_OP_SWAP: r = {a[3:0], a[7:4]};
            BSX_OP_IO_SET: r[sel] = 1'b1;
            BSX_OP_IO_CLR: r[sel] = 1'b0;
            BSX_OP_T_TO_BIT: r[sel] = status_flags_register[BSX_FLAG_T];
            BSX_OP_BIT_TO_T: status_flags_register[BSX_FLAG_T] = a[sel];
            BSX_OP_FLAG_SET: status_flags_register[sel] = 1'b1;
            BSX_OP_FLAG_CLR: status_flags_register[sel] = 1'b0;
            BSX_OP_PUSH: stk[sp] = a;
            BSX_OP_POP: r = stk[sp - 6'h1];
            default: r = a;
        endcase
        if (op inside {BSX_OP_LSL, BSX_OP_LSR, BSX_OP_ROL, BSX_OP_ROR,
                       BSX_OP_ASR}) begin
            c = (op == BSX_OP_LSL || op == BSX_OP_ROL) ? a[7] : a[0];
            status_flags_register[BSX_FLAG_C] = c;
            status_flags_register[BSX_FLAG_Z] = (r == 8'h00);
            status_flags_register[BSX_FLAG_N] = r[7];
            status_flags_register[BSX_FLAG_V] = r[7] ^ c;
            status_flags_register[BSX_FLAG_S] = c;
        end
        if (op == BSX_OP_PUSH) sp = sp + 6'h1;
        if (op == BSX_OP_POP) sp = sp - 6'h1;
        i_issue = 1'b1;
        i_op = op;
        i_operand = a;
        i_bit_sel = sel;
        tick(1);
        i_issue = 1'b0;
        wait_done();
        chk(cyc == (two ? BSX_CYC_TWO : BSX_CYC_ONE), "cycle count");
        chk(o_result_wr === wr, "write-back strobe");
        if (wr || op == BSX_OP_PUSH) chk(o_result === r, "result byte");
        chk(o_status_flags_register === status_flags_register, "status flags");
        chk(o_stack_ptr === sp, "stack pointer");
        chk(o_sleep_req === (op == BSX_OP_SLEEP), "sleep pulse");
        chk(o_wdog_rst === (op == BSX_OP_WDOG), "watchdog pulse");
    endtask

    initial begin
        i_arst_n = 1'b0;
        i_issue = 1'b0;
        i_op = BSX_OP_IDLE;
        i_operand = 8'h00;
        i_bit_sel = 3'h0;
        i_debug_en = 1'b0;
        status_flags_register = BSX_STATUS_FLAGS_REGISTER_RST;
        sp = 6'h00;
        mismatches = 0;
        checked = 0;
        tick(16);
        chk(o_status_flags_register === BSX_STATUS_FLAGS_REGISTER_RST && o_stack_ptr === sp, "reset values");
        i_arst_n = 1'b1;
        for (int s = 0; s < 8; s++) begin
            do_op(BSX_OP_FLAG_SET, 8'h00, 3'(s));
        end
        for (int s = 0; s < 8; s++) begin
            do_op(BSX_OP_FLAG_CLR, 8'h00, 3'(s));
        end
        $display("Test of flag operations done");
        foreach (vals[k]) begin
            do_op(BSX_OP_LSL, vals[k], 3'h0);
            do_op(BSX_OP_LSR, vals[k], 3'h0);
            do_op(BSX_OP_ROL, vals[k], 3'h0);
            do_op(BSX_OP_ROR, vals[k], 3'h0);
            do_op(BSX_OP_ASR, vals[k], 3'h0);
            do_op(BSX_OP_SWAP, vals[k], 3'h0);
            do_op(BSX_OP_BIT_TO_T, vals[k], 3'(k));
            do_op(BSX_OP_T_TO_BIT, vals[k], 3'(k + 3));
            do_op(BSX_OP_IO_SET, vals[k], 3'(k));
            do_op(BSX_OP_IO_CLR, vals[k], 3'(k + 1));
        end
        $display("Test of shift and bit operations done");
        do_op(BSX_OP_PUSH, 8'h5a, 3'h0);
        do_op(BSX_OP_PUSH, 8'ha5, 3'h0);
        do_op(BSX_OP_POP, 8'h00, 3'h0);
        do_op(BSX_OP_POP, 8'h00, 3'h0);
        // Issue stays high through the busy cycle; the second request is lost.
        i_issue = 1'b1;
        i_op = BSX_OP_PUSH;
        i_operand = 8'h33;
        stk[sp] = 8'h33;
        sp = sp + 6'h1;
        tick(1);
        i_op = BSX_OP_LSL;
        tick(1);
        i_issue = 1'b0;
        chk(o_busy === 1'b0 && o_done === 1'b1, "push timing");
        tick(1);
        chk(o_done === 1'b0 && o_status_flags_register === status_flags_register, "refused issue");
        $display("Test of stack operations done");
        do_op(BSX_OP_IDLE, 8'hff, 3'h7);
        do_op(BSX_OP_SLEEP, 8'h00, 3'h0);
        do_op(BSX_OP_WDOG, 8'h00, 3'h0);
        do_op(BSX_OP_BREAK, 8'h00, 3'h0);
        i_debug_en = 1'b1;
        i_issue = 1'b1;
        i_op = BSX_OP_BREAK;
        tick(1);
        i_issue = 1'b0;
        chk(o_break_req === 1'b1 && o_busy === 1'b1, "break request");
        tick(3);
        chk(o_busy === 1'b1 && o_done === 1'b0, "break halt");
        i_debug_en = 1'b0;
        wait_done();
        chk(o_status_flags_register === status_flags_register && o_stack_ptr === sp, "break left state");
        $display("Test of control operations done");
        test_done();
    end
endmodule // testbench

bind bsx_exec_unit bsx_exec_monitor u_mon (.i_sys_clk, .i_arst_n, .i_issue,
    .i_op, .i_operand, .i_bit_sel, .o_busy, .o_done, .o_result, .o_status_flags_register,
    .o_wdog_rst);
`default_nettype wire
